// file: rtl/erse_exec.sv
// execution datapath for the extended rotate, subtract-with-borrow,
// step-and-skip, set and bit-skip instructions
// assumes the sequencer issues one operation at a time on core_clk and the
// data memory returns read data one cycle after mem_rd_en
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (RL1) rotate_right_mem rotates the byte right, old bit 0 to bit 7, writes it back, no flags.
// (RL2) rotate_right_to_work puts the right-rotated byte in the working register, memory and flags kept.
// (RL3) rotate_right_through_carry_mem shifts right, old carry to bit 7, old bit 0 to carry, writes back.
// (RL4) rotate_right_through_carry_to_work does the same rotation into the working register only.
// (RL5) subtract_with_borrow_to_work computes work minus byte minus inverted carry into work, six flags.
// (RL6) subtract_with_borrow_to_mem computes the same difference and flags but writes the byte.
// (RL7) after a subtract with borrow, carry is 0 for a negative difference and 1 otherwise.
// (RL8) decrement_skip_if_zero writes byte minus one back and skips when it is zero, no flags.
// (RL9) decrement_skip_to_work puts byte minus one in work, memory kept, skips when zero, no flags.
// (RL10) a conditional skip that is taken adds a dummy cycle while the next instruction is fetched.
// (RL11) set_all_or_one_bit in byte form writes all ones to the byte and keeps the flags.
// (RL12) set_all_or_one_bit in bit form sets only the chosen bit and keeps the flags.
// (RL13) increment_skip_if_zero writes byte plus one back and skips when it is zero, no flags.
// (RL14) increment_skip_to_work puts byte plus one in work, memory kept, skips when zero, no flags.
// (RL15) skip_if_bit_nonzero skips when the chosen bit is one, continues when zero, no flags.
// (RL16) every operation addresses the full data memory directly, with no section select.
// (RL17) a taken skip advances the program counter past the next instruction with no writes for it.
module erse_exec (
	// clock, reset, enable
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	input  wire logic                       clk_en,
	// operation request from the sequencer
	input  wire logic                       op_valid,
	input  wire erse_pkg::erse_op_t         op_code,
	input  wire logic [erse_pkg::ADDR_W-1:0] op_addr,
	input  wire logic [erse_pkg::BIT_W-1:0]  op_bit,
	output logic                            op_ready,
	// completion to the sequencer
	output logic                            op_done,
	output logic [1:0]                      pc_step,
	output logic                            skip_active,
	// data memory
	output logic                            mem_rd_en,
	output logic [erse_pkg::ADDR_W-1:0]     mem_addr,
	input  wire logic [erse_pkg::DATA_W-1:0] mem_rdata,
	output logic                            mem_we,
	output logic [erse_pkg::DATA_W-1:0]     mem_wdata,
	// working register and carry loads from other instructions
	input  wire logic                       work_load,
	input  wire logic [erse_pkg::DATA_W-1:0] work_in,
	input  wire logic                       carry_load,
	input  wire logic                       carry_in,
	// working register and flags
	output logic [erse_pkg::DATA_W-1:0]     working_register,
	output logic                            carry_flag,
	output logic                            zero_flag,
	output logic                            half_carry_flag,
	output logic                            signed_range_exceeded_flag,
	output logic                            sign_carry_flag,
	output logic                            zero_borrow_flag
);

	// =======================================================
	// decode helpers
	function automatic logic op_to_mem(input erse_pkg::erse_op_t op);
		case (op)
			erse_pkg::OP_ROT_MEM,
			erse_pkg::OP_ROTC_MEM,
			erse_pkg::OP_SUBB_MEM,
			erse_pkg::OP_DEC_SKIP,
			erse_pkg::OP_SET_BYTE,
			erse_pkg::OP_SET_BIT,
			erse_pkg::OP_INC_SKIP: op_to_mem = 1'b1;
			default:               op_to_mem = 1'b0;
		endcase
	endfunction

	function automatic logic op_to_work(input erse_pkg::erse_op_t op);
		case (op)
			erse_pkg::OP_ROT_WORK,
			erse_pkg::OP_ROTC_WORK,
			erse_pkg::OP_SUBB_WORK,
			erse_pkg::OP_DEC_SKIP_W,
			erse_pkg::OP_INC_SKIP_W: op_to_work = 1'b1;
			default:                 op_to_work = 1'b0;
		endcase
	endfunction

	function automatic logic op_is_subb(input erse_pkg::erse_op_t op);
		op_is_subb = (op == erse_pkg::OP_SUBB_WORK) || (op == erse_pkg::OP_SUBB_MEM);
	endfunction

	function automatic logic op_is_rotc(input erse_pkg::erse_op_t op);
		op_is_rotc = (op == erse_pkg::OP_ROTC_MEM) || (op == erse_pkg::OP_ROTC_WORK);
	endfunction

	// =======================================================
	// reset release
	logic rst_meta_n;
	logic rst_sync_n;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// =======================================================
	// operation state
	erse_pkg::erse_state_t          state;
	erse_pkg::erse_state_t          next_state;
	erse_pkg::erse_op_t             op_r;
	logic [erse_pkg::ADDR_W-1:0]    addr_r;
	logic [erse_pkg::BIT_W-1:0]     bit_r;
	logic                           skip_r;

	// =======================================================
	// state decodes shared by the loads and the handshake
	wire in_idle   = (state == erse_pkg::ST_IDLE);
	wire in_fetch  = (state == erse_pkg::ST_FETCH);
	wire in_finish = (state == erse_pkg::ST_FINISH);
	wire in_dummy  = (state == erse_pkg::ST_DUMMY);

	wire take_op = in_idle && op_valid;

	always_comb begin
		next_state = state;
		case (state)
			erse_pkg::ST_IDLE:   if (op_valid) next_state = erse_pkg::ST_FETCH;
			erse_pkg::ST_FETCH:  next_state = erse_pkg::ST_EXEC;
			erse_pkg::ST_EXEC:   next_state = erse_pkg::ST_FINISH;
			erse_pkg::ST_FINISH: next_state = skip_r ? erse_pkg::ST_DUMMY : erse_pkg::ST_IDLE; // RL10
			erse_pkg::ST_DUMMY:  next_state = erse_pkg::ST_IDLE;
			default:             next_state = erse_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state  <= erse_pkg::ST_IDLE;
			op_r   <= erse_pkg::OP_ROT_MEM;
			addr_r <= '0;
			bit_r  <= '0;
		end else if (clk_en) begin
			state <= next_state;
			if (take_op) begin
				op_r   <= op_code;
				addr_r <= op_addr; // RL16
				bit_r  <= op_bit;
			end
		end
	end

	// =======================================================
	// arithmetic on the fetched byte
	wire [7:0] m = mem_rdata;

	// one-hot mask for the selected bit
	wire [7:0] bit_mask;
	genvar gi;
	generate
		for (gi = 0; gi < erse_pkg::DATA_W; gi++) begin : g_mask
			assign bit_mask[gi] = (bit_r == (erse_pkg::BIT_W)'(gi));
		end
	endgenerate

	wire [7:0] rot_plain = {m[erse_pkg::LSB], m[7:1]};                  // RL1 RL2
	wire [7:0] rot_carry = {carry_flag, m[7:1]};                        // RL3 RL4
	wire [7:0] dec_val   = m - erse_pkg::ONE;                           // RL8 RL9
	wire [7:0] inc_val   = m + erse_pkg::ONE;                           // RL13 RL14
	wire [7:0] setb_val  = m | bit_mask;                                // RL12
	wire       bit_hit   = |(m & bit_mask);                             // RL15

	// work minus byte minus inverted carry, as work plus inverted byte plus carry
	wire [8:0] sub_full  = {1'b0, working_register} + {1'b0, ~m} + {8'h00, carry_flag}; // RL5
	wire [4:0] sub_half  = {1'b0, working_register[3:0]} + {1'b0, ~m[3:0]}
		+ {4'h0, carry_flag};
	wire [7:0] sub_val   = sub_full[7:0];
	wire       sub_carry = sub_full[8];                                 // RL7
	wire       sub_zero  = (sub_val == erse_pkg::ALL_ZERO);
	wire       sub_ov    = (working_register[erse_pkg::MSB] != m[erse_pkg::MSB])
		&& (sub_val[erse_pkg::MSB] != working_register[erse_pkg::MSB]);
	wire       sub_sc    = sub_ov ^ sub_val[erse_pkg::MSB];

	// =======================================================
	// result selection
	logic [7:0] result;
	logic       skip_now;

	always_comb begin
		result   = m;
		skip_now = 1'b0;
		case (op_r)
			erse_pkg::OP_ROT_MEM,
			erse_pkg::OP_ROT_WORK:    result = rot_plain;                  // RL1 RL2
			erse_pkg::OP_ROTC_MEM,
			erse_pkg::OP_ROTC_WORK:   result = rot_carry;                  // RL3 RL4
			erse_pkg::OP_SUBB_WORK,
			erse_pkg::OP_SUBB_MEM:    result = sub_val;                    // RL5 RL6
			erse_pkg::OP_DEC_SKIP,
			erse_pkg::OP_DEC_SKIP_W: begin
				result   = dec_val;
				skip_now = (dec_val == erse_pkg::ALL_ZERO);                // RL8 RL9
			end
			erse_pkg::OP_SET_BYTE:    result = erse_pkg::ALL_ONES;         // RL11
			erse_pkg::OP_SET_BIT:     result = setb_val;                   // RL12
			erse_pkg::OP_INC_SKIP,
			erse_pkg::OP_INC_SKIP_W: begin
				result   = inc_val;
				skip_now = (inc_val == erse_pkg::ALL_ZERO);                // RL13 RL14
			end
			erse_pkg::OP_SKIP_BIT_NZ: skip_now = bit_hit;                  // RL15
			default: begin
				result   = m;
				skip_now = 1'b0;
			end
		endcase
	end

	// write targets: memory writers and working register writers never overlap
	wire in_exec     = (state == erse_pkg::ST_EXEC);
	wire exec_mem    = in_exec && op_to_mem(op_r);                      // RL1 RL3 RL6 RL8
	wire exec_work   = in_exec && op_to_work(op_r);                     // RL2 RL4 RL5 RL9 RL14
	wire exec_subb   = in_exec && op_is_subb(op_r);
	wire exec_rotc   = in_exec && op_is_rotc(op_r);

	// =======================================================
	// memory write and skip capture
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mem_we    <= 1'b0;
			mem_wdata <= erse_pkg::ALL_ZERO;
			skip_r    <= 1'b0;
			pc_step   <= erse_pkg::PC_STEP_NEXT;
		end else if (clk_en) begin
			mem_we <= exec_mem;                                             // RL1 RL3 RL8
			if (exec_mem) begin
				mem_wdata <= result;
			end
			if (in_exec) begin
				skip_r  <= skip_now;
				pc_step <= skip_now ? erse_pkg::PC_STEP_SKIP : erse_pkg::PC_STEP_NEXT; // RL17
			end
		end
	end

	// =======================================================
	// working register
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			working_register <= erse_pkg::WORK_RST;
		end else if (clk_en) begin
			if (exec_work) begin
				working_register <= result;                                 // RL2 RL5 RL9 RL14
			end else if (work_load && (state == erse_pkg::ST_IDLE)) begin
				working_register <= work_in;
			end
		end
	end

	// =======================================================
	// flags: only carry rotation, subtract with borrow and the idle carry load touch them
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			carry_flag                 <= erse_pkg::FLAG_RST;
			zero_flag                  <= erse_pkg::FLAG_RST;
			half_carry_flag            <= erse_pkg::FLAG_RST;
			signed_range_exceeded_flag <= erse_pkg::FLAG_RST;
			sign_carry_flag            <= erse_pkg::FLAG_RST;
			// chained zero starts set, else the and-chain could never rise
			zero_borrow_flag           <= erse_pkg::ZB_RST;
		end else if (clk_en) begin
			if (exec_rotc) begin
				carry_flag <= m[erse_pkg::LSB];                             // RL3 RL4
			end else if (exec_subb) begin
				carry_flag                 <= sub_carry;                    // RL7
				zero_flag                  <= sub_zero;                     // RL5 RL6
				half_carry_flag            <= sub_half[erse_pkg::HALF_BIT];
				signed_range_exceeded_flag <= sub_ov;
				sign_carry_flag            <= sub_sc;
				zero_borrow_flag           <= sub_zero && zero_borrow_flag;
			end else if (carry_load && in_idle) begin
				// outside loads only land between operations
				carry_flag <= carry_in;
			end
		end
	end

	// =======================================================
	// handshake outputs
	assign op_ready    = in_idle;
	assign mem_rd_en   = in_fetch;
	assign mem_addr    = addr_r;                                            // RL16
	// the dummy cycle blocks new requests, so the skipped slot writes nothing
	assign skip_active = in_dummy;                                          // RL17
	assign op_done     = (in_finish && !skip_r)
		|| in_dummy;                                                        // RL10

endmodule

`default_nettype wire

// file: rtl/erse_pkg.sv
// constants, opcodes and states for the extended rotate/subtract/skip datapath
// assumes a single-port data memory with one cycle of read latency
package erse_pkg;

	// =======================================================
	// data and address widths
	localparam int DATA_W = 8;
	localparam int ADDR_W = 10;
	localparam int BIT_W  = 3;

	// =======================================================
	// fixed values
	localparam logic [7:0] ALL_ONES  = 8'hFF;
	localparam logic [7:0] ALL_ZERO  = 8'h00;
	localparam logic [7:0] ONE       = 8'h01;
	localparam int         MSB       = 7;
	localparam int         LSB       = 0;
	localparam int         HALF_BIT  = 4;

	// =======================================================
	// reset values
	localparam logic [7:0] WORK_RST  = 8'h00;
	localparam logic       FLAG_RST  = 1'b0;
	localparam logic       ZB_RST    = 1'b1;

	// =======================================================
	// program counter steps reported at completion
	localparam logic [1:0] PC_STEP_NEXT = 2'h1;
	localparam logic [1:0] PC_STEP_SKIP = 2'h2;

	// =======================================================
	// operations
	typedef enum logic [3:0] {
		OP_ROT_MEM      = 4'h0,
		OP_ROT_WORK     = 4'h1,
		OP_ROTC_MEM     = 4'h2,
		OP_ROTC_WORK    = 4'h3,
		OP_SUBB_WORK    = 4'h4,
		OP_SUBB_MEM     = 4'h5,
		OP_DEC_SKIP     = 4'h6,
		OP_DEC_SKIP_W   = 4'h7,
		OP_SET_BYTE     = 4'h8,
		OP_SET_BIT      = 4'h9,
		OP_INC_SKIP     = 4'hA,
		OP_INC_SKIP_W   = 4'hB,
		OP_SKIP_BIT_NZ  = 4'hC
	} erse_op_t;

	// =======================================================
	// sequencing states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_FETCH  = 3'h1,
		ST_EXEC   = 3'h2,
		ST_FINISH = 3'h3,
		ST_DUMMY  = 3'h4
	} erse_state_t;

endpackage

// file: verif/erse_mem_model.sv
// data memory seen by the execute datapath, one cycle of read latency
// assumes the bench preloads and inspects mem through the hierarchy
`timescale 1ns/1ps
`default_nettype none
module erse_mem_model (
	// clock
	input  wire logic       core_clk,
	// memory port of the datapath
	input  wire logic       mem_rd_en,
	input  wire logic [9:0] mem_addr,
	input  wire logic       mem_we,
	input  wire logic [7:0] mem_wdata,
	output logic      [7:0] mem_rdata
);
	logic [7:0] mem [1024];

	initial mem_rdata = 8'hA5;

	// read data is only valid for the cycle after a read; otherwise it toggles
	always @(posedge core_clk) begin
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
		if (mem_rd_en)
			mem_rdata <= mem[mem_addr];
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule
`default_nettype wire

// file: verif/erse_exec_monitor.sv
// checker for the extended rotate, subtract and skip datapath
// assumes it is bound to erse_exec and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module erse_exec_monitor (
	// clock and reset
	input wire logic                          core_clk,
	input wire logic                          rst_n,
	// request and completion
	input wire logic                          clk_en,
	input wire logic                          op_valid,
	input wire erse_pkg::erse_op_t            op_code,
	input wire logic [erse_pkg::ADDR_W-1:0]   op_addr,
	input wire logic                          op_ready,
	input wire logic                          op_done,
	input wire logic [1:0]                    pc_step,
	input wire logic                          skip_active,
	// memory and state
	input wire logic                          mem_rd_en,
	input wire logic [erse_pkg::ADDR_W-1:0]   mem_addr,
	input wire logic                          mem_we,
	input wire logic [erse_pkg::DATA_W-1:0]   working_register,
	input wire logic                          zero_flag,
	input wire logic                          half_carry_flag,
	input wire logic                          signed_range_exceeded_flag,
	input wire logic                          sign_carry_flag,
	input wire logic                          zero_borrow_flag
);
	// =======================================================
	// helper logic
	erse_pkg::erse_op_t op_q;
	wire take = op_valid && op_ready && clk_en;
	wire is_sub = op_q == erse_pkg::OP_SUBB_WORK || op_q == erse_pkg::OP_SUBB_MEM;
	wire is_wr = op_q inside {erse_pkg::OP_ROT_MEM, erse_pkg::OP_ROTC_MEM,
		erse_pkg::OP_SUBB_MEM, erse_pkg::OP_DEC_SKIP, erse_pkg::OP_SET_BYTE,
		erse_pkg::OP_SET_BIT, erse_pkg::OP_INC_SKIP};
	wire [4:0] flags = {zero_flag, half_carry_flag, signed_range_exceeded_flag,
		sign_carry_flag, zero_borrow_flag};

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			op_q <= erse_pkg::OP_ROT_MEM;
		else if (take)
			op_q <= op_code;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// =======================================================
	// assertions
	AST_TAKE_READ: assert property (take |=> mem_rd_en && mem_addr == $past(op_addr))
		else $error("read does not follow an accepted request");
	AST_READ_CAUSE: assert property (mem_rd_en |-> $past(take))
		else $error("read without an accepted request");
	AST_DONE_TIME: assert property (take |-> ##3 (op_done or (##1 (op_done && skip_active))))
		else $error("completion not three or four cycles after take");
	AST_SKIP_STEP: assert property (skip_active |->
		op_done && pc_step == erse_pkg::PC_STEP_SKIP)
		else $error("skip cycle without skip step");
	AST_PLAIN_STEP: assert property (op_done && !skip_active |->
		pc_step == erse_pkg::PC_STEP_NEXT)
		else $error("plain completion with wrong step");
	AST_SKIP_QUIET: assert property (skip_active |-> !mem_we && $stable(working_register))
		else $error("write during skipped slot");
	AST_WE_SLOT: assert property (mem_we |-> $past(mem_rd_en, 2) && is_wr)
		else $error("memory write out of slot or by a non-writer");
	AST_FLAGS_SUB: assert property ($changed(flags) |-> is_sub && !op_ready)
		else $error("arithmetic flags changed outside a subtract");
	AST_WORK_DEST: assert property ($changed(working_register) && !op_ready
		&& !mem_rd_en |-> !is_wr && op_q != erse_pkg::OP_SKIP_BIT_NZ)
		else $error("working register changed by a memory-only operation");

	cover property (skip_active);
	cover property (mem_we && is_sub);
	cover property (take && op_code == erse_pkg::OP_SKIP_BIT_NZ);
endmodule

bind erse_exec erse_exec_monitor u_erse_exec_monitor (.core_clk, .rst_n, .clk_en, .op_valid,
	.op_code, .op_addr, .op_ready, .op_done, .pc_step, .skip_active, .mem_rd_en, .mem_addr,
	.mem_we, .working_register, .zero_flag, .half_carry_flag, .signed_range_exceeded_flag,
	.sign_carry_flag, .zero_borrow_flag);
`default_nettype wire

// file: verif/test_ext_rotate_sub_skip_exec.sv
// self-checking bench for the extended rotate, subtract and skip datapath
// assumes erse_exec, erse_mem_model and the bound monitor are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_ext_rotate_sub_skip_exec;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic op_valid = 1'b0, work_load = 1'b0, carry_load = 1'b0, carry_in = 1'b0;
	logic clk_en = 1'b1, zb_exp = erse_pkg::ZB_RST;
	erse_pkg::erse_op_t op_code = erse_pkg::OP_ROT_MEM;
	logic [9:0] op_addr = 10'h000, mem_addr;
	logic [2:0] op_bit = 3'h0;
	logic [7:0] work_in = 8'h00, mem_rdata, mem_wdata, working_register;
	logic [1:0] pc_step;
	logic op_ready, op_done, skip_active, mem_rd_en, mem_we, carry_flag, zero_flag;
	logic half_carry_flag, signed_range_exceeded_flag, sign_carry_flag, zero_borrow_flag;
	logic [7:0] corner [4] = '{8'h00, 8'h01, 8'hFF, 8'h80};
	int num_errors = 0, cmp_count = 0, seed = 87;

	always #10 core_clk = ~core_clk;

	erse_exec u_erse_exec (.core_clk, .rst_n, .clk_en, .op_valid, .op_code, .op_addr,
		.op_bit, .op_ready, .op_done, .pc_step, .skip_active, .mem_rd_en, .mem_addr,
		.mem_rdata, .mem_we, .mem_wdata, .work_load, .work_in, .carry_load, .carry_in,
		.working_register, .carry_flag, .zero_flag, .half_carry_flag,
		.signed_range_exceeded_flag, .sign_carry_flag, .zero_borrow_flag);

	erse_mem_model u_erse_mem_model (.core_clk, .mem_rd_en, .mem_addr, .mem_we, .mem_wdata,
		.mem_rdata);

	// =======================================================
	// checking and closing
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// =======================================================
	// expected outcome packed as {dest, skip, carry, result}; dest 1 memory, 2 working
	function automatic logic [11:0] expect_op(input int op, input logic [7:0] m, w,
			input logic c, input logic [2:0] b);
		logic [8:0] s;
		logic [7:0] r;
		logic [1:0] d;
		logic nc, sk;
		s = {1'b0, w} + {1'b0, ~m} + 9'(c);
		case (op)
			0, 1: r = {m[0], m[7:1]};
			2, 3: r = {c, m[7:1]};
			4, 5: r = s[7:0];
			6, 7: r = m - 8'h01;
			8: r = 8'hFF;
			9: r = m | (8'h01 << b);
			10, 11: r = m + 8'h01;
			default: r = m;
		endcase
		d = (op inside {0, 2, 5, 6, 8, 9, 10}) ? 2'h1 : (op == 12) ? 2'h0 : 2'h2;
		nc = (op == 2 || op == 3) ? m[0] : (op == 4 || op == 5) ? s[8] : c;
		sk = (op inside {6, 7, 10, 11}) ? (r == 8'h00) : (op == 12) ? m[b] : 1'b0;
		return {d, sk, nc, r};
	endfunction

	// =======================================================
	// one operation with working register and carry loaded first
	task automatic run_op(input int op, input logic [9:0] a, input logic [2:0] b,
			input logic [7:0] m, w, input logic c);
		logic [11:0] e;
		logic [4:0] h;
		int n;
		e = expect_op(op, m, w, c, b);
		h = {1'b0, w[3:0]} + {1'b0, ~m[3:0]} + 5'(c);
		u_erse_mem_model.mem[a] = m;
		@(posedge core_clk);
		work_load <= 1'b1;
		work_in <= w;
		carry_load <= 1'b1;
		carry_in <= c;
		@(posedge core_clk);
		work_load <= 1'b0;
		carry_load <= 1'b0;
		op_valid <= 1'b1;
		op_code <= erse_pkg::erse_op_t'(op);
		op_addr <= a;
		op_bit <= b;
		@(posedge core_clk);
		op_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (op_done !== 1'b1 && n < 10);
		chk(8'(n), e[9] ? 8'h04 : 8'h03, "cycles to done");
		chk(8'(pc_step), e[9] ? 8'h02 : 8'h01, "pc step");
		@(negedge core_clk);
		chk(u_erse_mem_model.mem[a], e[11:10] == 2'h1 ? e[7:0] : m, "memory");
		chk(working_register, e[11:10] == 2'h2 ? e[7:0] : w, "working register");
		chk(8'(carry_flag), 8'(e[8]), "carry");
		if (op == 4 || op == 5) begin
			chk(8'(zero_flag), 8'(e[7:0] == 8'h00), "zero flag");
			chk(8'(half_carry_flag), 8'(h[4]), "half carry");
			chk(8'(signed_range_exceeded_flag), 8'(w[7] != m[7] && e[7] != w[7]), "ov");
			chk(8'(sign_carry_flag), 8'((w[7] != m[7] && e[7] != w[7]) ^ e[7]), "sc");
			zb_exp = zb_exp && (e[7:0] == 8'h00);
			chk(8'(zero_borrow_flag), 8'(zb_exp), "zero borrow");
		end
	endtask

	initial begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (int op = 0; op < 13; op++)
			for (int k = 0; k < 4; k++)
				run_op(op, k[0] ? 10'h3FF : 10'h000, 3'(k + 5), corner[k], corner[3 - k], k[1]);
		// frozen enable: idle loads must not land; last corner left work 00, carry 1
		@(posedge core_clk);
		clk_en <= 1'b0;
		work_load <= 1'b1;
		work_in <= 8'hFF;
		carry_load <= 1'b1;
		carry_in <= 1'b0;
		repeat (3) @(posedge core_clk);
		clk_en <= 1'b1;
		work_load <= 1'b0;
		carry_load <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
		chk(working_register, 8'h00, "working register under frozen enable");
		chk(8'(carry_flag), 8'h01, "carry under frozen enable");
		$display("corner tests done");
		repeat (300)
			run_op($unsigned($random(seed)) % 13, 10'($random(seed)), 3'($random(seed)),
				8'($random(seed)), 8'($random(seed)), 1'($random(seed)));
		$display("random tests done");
		test_done;
	end

	initial begin
		#1000000;
		num_errors++;
		test_done;
	end
endmodule
`default_nettype wire
